// ==== inc/fnr_regs.vh ====
// Constants for the float negate/round/root/subtract/store unit
`ifndef FNR_REGS_VH
`define FNR_REGS_VH
// Instruction fields and codes
`define FNR_F_OPC 31:26
`define FNR_F_FMT 25:21
`define FNR_F_RT 20:16
`define FNR_F_FD 10:6
`define FNR_F_FN 5:0
`define FNR_F_OFS 15:0
`define FNR_F_SGN 15
`define FNR_OP_FLOAT_COPROCESSOR 6'h11
`define FNR_OP_SDC 6'h3d
`define FNR_FN_SUB 6'h01
`define FNR_FN_SQRT 6'h04
`define FNR_FN_NEG 6'h07
`define FNR_FN_RNDL 6'h08
`define FNR_FN_RNDW 6'h0c
`define FNR_FMT_S 5'h10
`define FNR_FMT_D 5'h11
// Register byte offsets
`define FNR_A_FCS 8'h00
`define FNR_A_IST 8'h04
`define FNR_A_IMSK 8'h08
`define FNR_A_CFG 8'h0c
// Control/status fields
`define FNR_FCS_RM 1:0
`define FNR_FCS_FLAG 2
`define FNR_FCS_EN 3
`define FNR_CFG_FR32 0
`define FNR_IRQ_W 3
// Rounding modes
`define FNR_RM_RN 2'h0
`define FNR_RM_RZ 2'h1
`define FNR_RM_RP 2'h2
`define FNR_RM_RM 2'h3
// Exception codes
`define FNR_X_NONE 4'h0
`define FNR_X_COPU 4'h1
`define FNR_X_RSVD 4'h2
`define FNR_X_INV 4'h4
`define FNR_X_ADDR 4'h5
`define FNR_X_REFILL 4'h6
`define FNR_X_TLBINV 4'h7
`define FNR_X_TLBMOD 4'h8
// Unpacked operand layout
`define FNR_U_NAN 69
`define FNR_U_INF 68
`define FNR_U_ZERO 67
`define FNR_U_SGN 66
`define FNR_U_EXP 65:53
`define FNR_U_MAN 52:0
// Format figures
`define FNR_BIAS_D 13'h3ff
`define FNR_BIAS_S 13'h07f
`define FNR_EMIN_D 13'h1c02
`define FNR_EMIN_S 13'h1f82
`define FNR_SH_D 7'h0b
`define FNR_SH_S 7'h28
`define FNR_QNAN_D 64'h7ff7ffffffffffff
`define FNR_QNAN_S 64'h000000007fbfffff
`define FNR_MAX_L 64'h7fffffffffffffff
`define FNR_MAX_W 64'h000000007fffffff
`define FNR_ROOT_W 56
`endif

// ==== rtl/fnr_root.v ====
// Restoring square root engine, one root bit per cycle
`default_nettype none
module fnr_root #(
  parameter RW = 56
) (
  input  wire            core_clk,
  input  wire            nrst,
  input  wire            start,
  input  wire [2*RW-1:0] radicand,
  output reg             done,
  output reg  [RW-1:0]   root,
  output reg             inexact
);
  reg  [2*RW-1:0] rad;
  reg  [RW+1:0]   rem;
  reg  [7:0]      cnt;
  reg             busy;
  wire [RW+3:0]   part;
  wire [RW+3:0]   trial;
  wire            ge;
  wire [RW+3:0]   diff;
  wire [RW+1:0]   next_rem;

  // Bring down two radicand bits, try root*4+1
  assign part = {rem, rad[2*RW-1:2*RW-2]};
  assign trial = {2'h0, root, 2'h1};
  assign ge = part >= trial;
  assign diff = part - trial;
  assign next_rem = ge ? diff[RW+1:0] : part[RW+1:0];

  // Iterate RW times; remainder left over marks an inexact root
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rad <= {2*RW{1'b0}};
      rem <= {(RW+2){1'b0}};
      root <= {RW{1'b0}};
      cnt <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      inexact <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rad <= radicand;
        rem <= {(RW+2){1'b0}};
        root <= {RW{1'b0}};
        cnt <= 8'h00;
        busy <= 1'b1;
      end else if (busy) begin
        rad <= rad << 2;
        rem <= next_rem;
        root <= {root[RW-2:0], ge};
        cnt <= cnt + 8'h01;
        if (cnt == RW - 1) begin
          busy <= 1'b0;
          done <= 1'b1;
          inexact <= |next_rem;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fnr_exec.v ====
// Float unit: negate, round to integer, root, subtract, doubleword store
//
// The Wishbone register port and the register addresses are this design's own decisions.
`include "fnr_regs.vh"
`default_nettype none
// Operation
// - Negate: opcode 010001, function 000111, bits 20..16 zero; flip sign.
// - Negating a NaN raises invalid operation, it is not passed through.
// - Round to long: nearest even, 64-bit signed; default 2^63-1.
// - Round to word (001100): nearest even, 32-bit; default 2^31-1.
// - Infinity, NaN or out-of-range rounded integer: invalid operation.
// - Invalid operation always sets the invalid flag in control/status.
// - Invalid enabled: no destination write, immediate exception.
// - Store is opcode 111101; address is base plus signed offset; 64 bits.
// - With 32-bit float registers: low word even register, high word odd.
// - Store address with low three bits nonzero: address error, no write.
// - Store reports unusable, refill, TLB invalid, TLB modified.
// - Root is function 000100, exact then rounded by current mode.
// - Root of negative zero is negative zero, no invalid operation.
// - Root of an operand below zero raises invalid operation.
// - Subtract is function 000001: first minus second, rounded by mode.
// - Negate never raises inexact, overflow or underflow.
module fnr_exec (
  input  wire        core_clk,
  input  wire        nrst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        issue_valid,
  output reg         issue_ready,
  input  wire [31:0] issue_instr,
  input  wire [63:0] op_first,
  input  wire [63:0] op_second,
  input  wire [63:0] base_value,
  input  wire        cop_usable,
  input  wire        tlb_refill,
  input  wire        tlb_invalid,
  input  wire        tlb_modified,
  output reg         res_we,
  output reg  [4:0]  res_idx,
  output reg  [63:0] res_data,
  output reg         mem_we,
  output reg  [63:0] mem_addr,
  output reg  [63:0] mem_data,
  output reg         exc_valid,
  output reg  [3:0]  exc_code,
  output reg         irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_ROOT = 2'h2;
  localparam ST_RND = 2'h3;

  // Leading zero count; zero input gives zero
  function [5:0] lzc64;
    input [63:0] v;
    integer i;
    begin
      lzc64 = 6'h00;
      for (i = 0; i < 64; i = i + 1)
        if (v[i]) lzc64 = 6'h3f - i[5:0];
    end
  endfunction

  // Raw value to flags, sign, exponent, mantissa
  function [69:0] unpack;
    input [63:0] r;
    input        d;
    reg   [10:0] e;
    reg   [51:0] f;
    reg   [63:0] m;
    reg   [5:0]  lz;
    reg   [12:0] ex;
    reg   [12:0] bias;
    reg          mx;
    begin
      e = d ? r[62:52] : {3'h0, r[30:23]};
      f = d ? r[51:0] : {r[22:0], 29'h0};
      mx = d ? &e : &e[7:0];
      bias = d ? `FNR_BIAS_D : `FNR_BIAS_S;
      lz = lzc64({12'h000, f});
      if (e != 11'h000) begin
        m = {11'h000, 1'b1, f};
        ex = {2'h0, e} - bias;
      end else begin
        // Subnormal: leading one up to bit 52
        m = {12'h000, f} << (lz - 6'h0b);
        ex = 13'h001 - bias - {7'h00, lz} + 13'h00b;
      end
      unpack = {mx & (f != 52'h0), mx & (f == 52'h0),
                (e == 11'h000) & (f == 52'h0),
                d ? r[63] : r[31], ex, m[52:0]};
    end
  endfunction

  // Infinity of either format
  function [63:0] inf_pat;
    input s;
    input d;
    begin
      inf_pat = d ? {s, 11'h7ff, 52'h0} : {32'h0, s, 8'hff, 23'h0};
    end
  endfunction

  reg [1:0]  state;
  reg [31:0] ins;
  reg [63:0] va;
  reg [63:0] vb;
  reg [63:0] base_r;
  reg [1:0]  rnd_mode;
  reg        inv_flag;
  reg        inv_en;
  reg        fr32;
  reg [`FNR_IRQ_W-1:0] irq_st;
  reg [`FNR_IRQ_W-1:0] irq_msk;
  reg        r_sign;
  reg signed [12:0] r_exp;
  reg [63:0] r_mant;
  reg        root_go;
  wire       root_done;
  wire       root_inx;
  wire [`FNR_ROOT_W-1:0] root_val;

  // Held instruction decode
  wire [4:0]  fmt = ins[`FNR_F_FMT];
  wire [5:0]  fn = ins[`FNR_F_FN];
  wire        dbl = fmt == `FNR_FMT_D;
  wire        fmt_ok = dbl | (fmt == `FNR_FMT_S);
  wire        is_st = ins[`FNR_F_OPC] == `FNR_OP_SDC;
  wire        is_float_coprocessor = ins[`FNR_F_OPC] == `FNR_OP_FLOAT_COPROCESSOR;
  wire        rt_z = ins[`FNR_F_RT] == 5'h00;
  wire        fn_ok = (fn == `FNR_FN_SUB) |
                      (rt_z & ((fn == `FNR_FN_NEG) | (fn == `FNR_FN_SQRT) |
                      (fn == `FNR_FN_RNDL) | (fn == `FNR_FN_RNDW)));
  wire        op_ok = is_float_coprocessor & fmt_ok & fn_ok;
  wire [63:0] ea = base_r + {{48{ins[`FNR_F_SGN]}}, ins[`FNR_F_OFS]};

  wire [69:0] ua = unpack(va, dbl);
  wire [69:0] ub = unpack(vb, dbl);
  wire signed [12:0] ua_e = ua[`FNR_U_EXP];
  wire        sa = ua[`FNR_U_SGN];
  wire        sbe = ~ub[`FNR_U_SGN];
  wire [63:0] qnan = dbl ? `FNR_QNAN_D : `FNR_QNAN_S;
  wire [63:0] sgn_bit = dbl ? {1'b1, 63'h0} : {32'h0, 1'b1, 31'h0};
  wire [2*`FNR_ROOT_W-1:0] rad = ua_e[0] ?
       {ua[`FNR_U_MAN], 1'b0, 58'h0} : {1'b0, ua[`FNR_U_MAN], 58'h0};

  // Round to integer: nearest even, mode ignored
  reg signed [12:0] cv_e;
  reg [127:0] cv_t;
  reg [64:0]  cv_mag;
  reg [64:0]  cv_lim;
  reg [63:0]  cv_neg;
  reg [63:0]  cv_res;
  reg         cv_inv;
  reg         cv_w;
  always @* begin
    cv_w = fn == `FNR_FN_RNDW;
    cv_e = ua_e;
    cv_t = {ua[`FNR_U_MAN], 75'h0} >> (7'h3f - cv_e[6:0]);
    cv_mag = {1'b0, cv_t[127:64]} +
             {64'h0, cv_t[63] & ((|cv_t[62:0]) | cv_t[64])};
    if (ua[`FNR_U_ZERO] | (cv_e < 13'sh1fff))
      cv_mag = 65'h0;
    cv_lim = {1'b0, cv_w ? `FNR_MAX_W : `FNR_MAX_L} + {64'h0, sa};
    cv_inv = ua[`FNR_U_NAN] | ua[`FNR_U_INF] |
             (cv_e > 13'sh03f) | (cv_mag > cv_lim);
    cv_neg = 64'h0 - cv_mag[63:0];
    cv_res = sa ? cv_neg : cv_mag[63:0];
    if (cv_w)
      cv_res = {32'h0, cv_res[31:0]};
  end

  // Subtract: align, add or take difference, normalise
  reg         sb_big;
  reg [63:0]  sb_x;
  reg [63:0]  sb_y;
  reg [12:0]  sb_ea;
  reg [12:0]  sb_eb;
  reg [12:0]  sb_ex;
  reg [12:0]  sb_d;
  reg         sb_sx;
  reg         sb_sy;
  reg [63:0]  sb_sum;
  reg [5:0]   sb_lz;
  reg [63:0]  sb_m;
  reg [12:0]  sb_e;
  reg         sb_sg;
  always @* begin
    // A zero operand gets the lowest exponent so it never leads a nonzero operand
    sb_ea = ua[`FNR_U_ZERO] ? 13'h1000 : ua[`FNR_U_EXP];
    sb_eb = ub[`FNR_U_ZERO] ? 13'h1000 : ub[`FNR_U_EXP];
    sb_big = ($signed(sb_ea) > $signed(sb_eb)) |
             ((sb_ea == sb_eb) & (ua[`FNR_U_MAN] >= ub[`FNR_U_MAN]));
    sb_x = {1'b0, sb_big ? ua[`FNR_U_MAN] : ub[`FNR_U_MAN], 10'h0};
    sb_y = {1'b0, sb_big ? ub[`FNR_U_MAN] : ua[`FNR_U_MAN], 10'h0};
    sb_ex = sb_big ? sb_ea : sb_eb;
    sb_d = sb_big ? sb_ea - sb_eb : sb_eb - sb_ea;
    sb_sx = sb_big ? sa : sbe;
    sb_sy = sb_big ? sbe : sa;
    // Shifted-out bits fold into sticky
    if (sb_d > 13'h03f)
      sb_y = {63'h0, |sb_y};
    else
      sb_y = (sb_y >> sb_d[5:0]) |
             {63'h0, |(sb_y << (7'h40 - sb_d[6:0]))};
    sb_sum = (sb_sx == sb_sy) ? sb_x + sb_y : sb_x - sb_y;
    sb_lz = lzc64(sb_sum);
    sb_m = sb_sum << sb_lz;
    sb_e = sb_ex + 13'h001 - {7'h00, sb_lz};
    // Exact zero: like signs keep it, unlike give +0 except toward minus
    sb_sg = (sb_sum == 64'h0) ?
            ((sa == sbe) ? sa : (rnd_mode == `FNR_RM_RM)) : sb_sx;
  end

  // Shared rounder, current mode
  reg [63:0] rm_m;
  reg [63:0] rm_k;
  reg [63:0] rm_rest;
  reg [12:0] rm_e;
  reg [12:0] rm_emin;
  reg [12:0] rm_emax;
  reg [12:0] rm_bias;
  reg [12:0] rm_dsh;
  reg [12:0] rm_be;
  reg [6:0]  rm_psh;
  reg        rm_g;
  reg        rm_s;
  reg        rm_inc;
  reg        rm_inf;
  reg [63:0] rnd_out;
  always @* begin
    rm_psh = dbl ? `FNR_SH_D : `FNR_SH_S;
    rm_emin = dbl ? `FNR_EMIN_D : `FNR_EMIN_S;
    rm_bias = dbl ? `FNR_BIAS_D : `FNR_BIAS_S;
    rm_emax = rm_bias;
    rm_m = r_mant;
    rm_e = r_exp;
    rm_dsh = rm_emin - r_exp;
    // Below normal range: denormalise, keep sticky
    if ($signed(r_exp) < $signed(rm_emin)) begin
      if (rm_dsh > 13'h03f)
        rm_m = {63'h0, |r_mant};
      else
        rm_m = (r_mant >> rm_dsh[5:0]) |
               {63'h0, |(r_mant << (7'h40 - rm_dsh[6:0]))};
      rm_e = rm_emin;
    end
    rm_k = rm_m >> rm_psh;
    rm_rest = rm_m << (7'h40 - rm_psh);
    rm_g = rm_rest[63];
    rm_s = |rm_rest[62:0];
    case (rnd_mode)
      `FNR_RM_RN: rm_inc = rm_g & (rm_s | rm_k[0]);
      `FNR_RM_RZ: rm_inc = 1'b0;
      `FNR_RM_RP: rm_inc = ~r_sign & (rm_g | rm_s);
      default:    rm_inc = r_sign & (rm_g | rm_s);
    endcase
    rm_k = rm_k + {63'h0, rm_inc};
    if (dbl ? rm_k[53] : rm_k[24]) begin
      rm_k = rm_k >> 1;
      rm_e = rm_e + 13'h001;
    end
    rm_be = (dbl ? rm_k[52] : rm_k[23]) ? rm_e + rm_bias : 13'h000;
    // Overflow: infinity or largest finite, by mode
    if ($signed(rm_e) > $signed(rm_emax)) begin
      rm_inf = (rnd_mode == `FNR_RM_RN) |
               ((rnd_mode == `FNR_RM_RP) & ~r_sign) |
               ((rnd_mode == `FNR_RM_RM) & r_sign);
      rm_be = rm_emax + rm_bias + {12'h000, rm_inf};
      rm_k = rm_inf ? 64'h0 : {64{1'b1}};
    end else
      rm_inf = 1'b0;
    rnd_out = dbl ? {r_sign, rm_be[10:0], rm_k[51:0]} :
              {32'h0, r_sign, rm_be[7:0], rm_k[22:0]};
  end

  // Completion, exception, dispatch
  reg        fin;
  reg        fin_inv;
  reg [63:0] fin_data;
  reg        go_sub;
  reg        go_root;
  reg        st_go;
  reg [3:0]  exc_n;
  always @* begin
    fin = 1'b0;
    fin_inv = 1'b0;
    fin_data = 64'h0;
    go_sub = 1'b0;
    go_root = 1'b0;
    st_go = 1'b0;
    exc_n = `FNR_X_NONE;
    if (state == ST_RND) begin
      fin = 1'b1;
      fin_data = rnd_out;
    end else if (state == ST_EXEC) begin
      if (!cop_usable)
        exc_n = `FNR_X_COPU;
      else if (is_st) begin
        if (ea[2:0] != 3'h0)
          exc_n = `FNR_X_ADDR;
        else if (tlb_refill)
          exc_n = `FNR_X_REFILL;
        else if (tlb_invalid)
          exc_n = `FNR_X_TLBINV;
        else if (tlb_modified)
          exc_n = `FNR_X_TLBMOD;
        else
          st_go = 1'b1;
      end else if (!op_ok)
        exc_n = `FNR_X_RSVD;
      else
        case (fn)
          `FNR_FN_NEG: begin
            // Sign flip, except a NaN becomes the default quiet NaN
            fin = 1'b1;
            fin_inv = ua[`FNR_U_NAN];
            fin_data = fin_inv ? qnan : va ^ sgn_bit;
          end
          `FNR_FN_RNDL, `FNR_FN_RNDW: begin
            fin = 1'b1;
            fin_inv = cv_inv;
            fin_data = cv_inv ? (cv_w ? `FNR_MAX_W : `FNR_MAX_L)
                              : cv_res;
          end
          `FNR_FN_SQRT: begin
            if (ua[`FNR_U_NAN] | (sa & ~ua[`FNR_U_ZERO])) begin
              fin = 1'b1;
              fin_inv = 1'b1;
              fin_data = qnan;
            end else if (ua[`FNR_U_ZERO] | ua[`FNR_U_INF]) begin
              fin = 1'b1;
              fin_data = va;
            end else
              go_root = 1'b1;
          end
          default: begin
            if (ua[`FNR_U_NAN] | ub[`FNR_U_NAN] |
                (ua[`FNR_U_INF] & ub[`FNR_U_INF] & (sa != sbe))) begin
              fin = 1'b1;
              fin_inv = 1'b1;
              fin_data = qnan;
            end else if (ua[`FNR_U_INF] | ub[`FNR_U_INF]) begin
              fin = 1'b1;
              fin_data = inf_pat(ua[`FNR_U_INF] ? sa : sbe, dbl);
            end else
              go_sub = 1'b1;
          end
        endcase
    end
  end

  wire inv_trap = fin & fin_inv & inv_en;
  wire [`FNR_IRQ_W-1:0] ev = {(fin & ~inv_trap) | st_go,
                              inv_trap | (exc_n != `FNR_X_NONE),
                              fin & fin_inv};

  // Operation sequencer and result ports
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      ins <= 32'h0;
      va <= 64'h0;
      vb <= 64'h0;
      base_r <= 64'h0;
      issue_ready <= 1'b0;
      r_sign <= 1'b0;
      r_exp <= 13'h0;
      r_mant <= 64'h0;
      root_go <= 1'b0;
      res_we <= 1'b0;
      res_idx <= 5'h00;
      res_data <= 64'h0;
      mem_we <= 1'b0;
      mem_addr <= 64'h0;
      mem_data <= 64'h0;
      exc_valid <= 1'b0;
      exc_code <= `FNR_X_NONE;
    end else begin
      res_we <= 1'b0;
      mem_we <= 1'b0;
      exc_valid <= 1'b0;
      root_go <= 1'b0;
      case (state)
        ST_IDLE: begin
          issue_ready <= 1'b1;
          if (issue_valid & issue_ready) begin
            issue_ready <= 1'b0;
            ins <= issue_instr;
            va <= op_first;
            vb <= op_second;
            base_r <= base_value;
            state <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (go_sub) begin
            r_sign <= sb_sg;
            r_exp <= sb_e;
            r_mant <= sb_m;
            state <= ST_RND;
          end else if (go_root) begin
            root_go <= 1'b1;
            r_sign <= 1'b0;
            r_exp <= ua_e >>> 1;
            state <= ST_ROOT;
          end else
            state <= ST_IDLE;
        end
        ST_ROOT: begin
          if (root_done) begin
            r_mant <= {root_val, 7'h00, root_inx};
            state <= ST_RND;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Trapped invalid: exception, no write
      if (fin) begin
        res_idx <= ins[`FNR_F_FD];
        res_data <= fin_data;
        if (inv_trap) begin
          exc_valid <= 1'b1;
          exc_code <= `FNR_X_INV;
        end else
          res_we <= 1'b1;
      end
      if (exc_n != `FNR_X_NONE) begin
        exc_valid <= 1'b1;
        exc_code <= exc_n;
      end
      if (st_go) begin
        mem_we <= 1'b1;
        mem_addr <= ea;
        mem_data <= fr32 ? {vb[31:0], va[31:0]} : va;
      end
    end
  end

  fnr_root #(
    .RW (`FNR_ROOT_W)
  ) u_root (
    .core_clk (core_clk),
    .nrst     (nrst),
    .start    (root_go),
    .radicand (rad),
    .done     (root_done),
    .root     (root_val),
    .inexact  (root_inx)
  );

  // Register slave: writes land on the edge that sees ack high
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      rnd_mode <= `FNR_RM_RN;
      inv_flag <= 1'b0;
      inv_en <= 1'b0;
      fr32 <= 1'b0;
      irq_st <= {`FNR_IRQ_W{1'b0}};
      irq_msk <= {`FNR_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit & ~wb_we_i)
        case (wb_adr_i)
          `FNR_A_FCS: wb_dat_o <= {28'h0, inv_en, inv_flag, rnd_mode};
          `FNR_A_IST: wb_dat_o <= {29'h0, irq_st};
          `FNR_A_IMSK: wb_dat_o <= {29'h0, irq_msk};
          `FNR_A_CFG: wb_dat_o <= {31'h0, fr32};
          default: wb_dat_o <= 32'h0;
        endcase
      if (wb_wr & (wb_adr_i == `FNR_A_FCS)) begin
        rnd_mode <= wb_dat_i[`FNR_FCS_RM];
        inv_en <= wb_dat_i[`FNR_FCS_EN];
      end
      if (wb_wr & (wb_adr_i == `FNR_A_CFG))
        fr32 <= wb_dat_i[`FNR_CFG_FR32];
      if (wb_wr & (wb_adr_i == `FNR_A_IMSK))
        irq_msk <= wb_dat_i[`FNR_IRQ_W-1:0];
      // Hardware set beats a software clear in the same cycle
      inv_flag <= (fin & fin_inv) | ((wb_wr & (wb_adr_i == `FNR_A_FCS)) ?
                  wb_dat_i[`FNR_FCS_FLAG] : inv_flag);
      irq_st <= ev | (irq_st & ~((wb_wr & (wb_adr_i == `FNR_A_IST)) ?
                wb_dat_i[`FNR_IRQ_W-1:0] : {`FNR_IRQ_W{1'b0}}));
      irq <= |(irq_st & irq_msk);
    end
  end
endmodule
`default_nettype wire

// ==== verification/fnr_exec_asserts.sv ====
// Port-level timing and result checks for the float unit
`default_nettype none
module fnr_exec_asserts (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        issue_valid,
  input wire logic        issue_ready,
  input wire logic [31:0] issue_instr,
  input wire logic [63:0] op_first,
  input wire logic [63:0] base_value,
  input wire logic        cop_usable,
  input wire logic        res_we,
  input wire logic [63:0] res_data,
  input wire logic        mem_we,
  input wire logic        exc_valid,
  input wire logic [3:0]  exc_code
);
  timeunit 1ns;
  timeprecision 1ps;
  // Taken request, any answer, store address
  wire tk = issue_valid && issue_ready;
  wire rs = res_we || mem_we || exc_valid;
  wire [63:0] ea = base_value + {{48{issue_instr[15]}}, issue_instr[15:0]};
  // Double negate of a finite operand
  wire ng = tk && issue_instr[31:16] == 16'h4620 &&
    issue_instr[5:0] == 6'h07 && !(&op_first[62:52]);
  wire st = tk && issue_instr[31:26] == 6'h3d && ea[2:0] != 3'h0;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ready_drops: assert property (tk |=> !issue_ready)
    else $error("ready held");
  a_one_result: assert property ($onehot0({res_we, mem_we, exc_valid}))
    else $error("two answers");
  a_answer_bound: assert property (tk |-> ##[2:64] rs)
    else $error("no answer");
  a_ready_back: assert property (rs |-> ##[1:2] issue_ready)
    else $error("ready stuck");
  a_neg_sign: assert property (ng |-> ##2 !$past(cop_usable) ||
    res_we && res_data == {~$past(op_first[63], 2),
    $past(op_first[62:0], 2)}) else $error("negate wrong");
  a_store_align: assert property (st |-> ##2 !$past(cop_usable) ||
    exc_valid && exc_code == 4'h5) else $error("misalign missed");
endmodule
bind fnr_exec fnr_exec_asserts u_chk (.*);
`default_nettype wire

// ==== verification/fnr_pipe_model.sv ====
// Issue-side pipeline model: holds a request until taken
`default_nettype none
module fnr_pipe_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [31:0] in_instr,
  input  wire logic [63:0] in_a,
  input  wire logic [63:0] in_b,
  input  wire logic [63:0] in_base,
  input  wire logic [3:0]  in_flg,
  input  wire logic        issue_ready,
  input  wire logic        ans,
  output var  logic        issue_valid,
  output var  logic [31:0] issue_instr,
  output var  logic [63:0] op_first,
  output var  logic [63:0] op_second,
  output var  logic [63:0] base_value,
  output var  logic [3:0]  flg
);
  timeunit 1ns;
  timeprecision 1ps;
  // Operands flip after the answer so a late sample is caught
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      issue_valid <= 1'b0;
      flg <= 4'h0;
    end else if (go) begin
      issue_valid <= 1'b1;
      issue_instr <= in_instr;
      op_first <= in_a;
      op_second <= in_b;
      base_value <= in_base;
      flg <= in_flg;
    end else if (issue_valid && issue_ready) begin
      issue_valid <= 1'b0;
    end else if (ans) begin
      op_first <= ~op_first;
      op_second <= ~op_second;
      base_value <= ~base_value;
    end
  end
endmodule
`default_nettype wire

// ==== verification/fnr_exec_tb.sv ====
// Self-checking bench for the float unit
`include "fnr_regs.vh"
`default_nettype none
module fnr_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] k; logic [4:0] i; logic [63:0] d, a;} fnr_exp_t;
  logic core_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic go = 0, wb_ack_o, issue_valid, issue_ready, res_we, mem_we, exc_valid;
  logic irq;
  logic [7:0] wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, in_instr = 0, wb_dat_o, issue_instr, rd;
  logic [63:0] in_a = 0, in_b = 0, in_base = 0, r, ea;
  logic [63:0] op_first, op_second, base_value, res_data, mem_addr, mem_data;
  logic [4:0] res_idx;
  logic [3:0] in_flg = 4'h8, flg, exc_code;
  logic [15:0] off;
  integer n_fail = 0, check_count = 0, seed = 32'h1e18778d, i;
  fnr_exp_t q[$], ex;
  logic [3:0] ft4 [4] = '{4'h0, 4'hc, 4'ha, 4'h9};
  logic [3:0] xc4 [4] = '{4'h1, 4'h6, 4'h7, 4'h8};
  always #5 core_clk = ~core_clk;
  fnr_exec dut (.core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .issue_valid,
    .issue_ready, .issue_instr, .op_first, .op_second, .base_value,
    .cop_usable(flg[3]), .tlb_refill(flg[2]), .tlb_invalid(flg[1]),
    .tlb_modified(flg[0]), .res_we, .res_idx, .res_data, .mem_we, .mem_addr,
    .mem_data, .exc_valid, .exc_code, .irq);
  fnr_pipe_model pm (.core_clk, .nrst, .go, .in_instr, .in_a, .in_b,
    .in_base, .in_flg, .issue_ready, .ans(res_we | mem_we | exc_valid),
    .issue_valid, .issue_instr, .op_first, .op_second, .base_value, .flg);
  task automatic chk(input logic [63:0] s, x, input string m);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Classic cycle: held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    integer t;
    t = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= ad;
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1 && ++t < 50);
    if (t >= 50) n_fail++;
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    wb(0, ad, 0);
    chk(64'(rd), 64'(x), "register");
  endtask
  // Queue expectation, issue, await answer
  task automatic op(input logic [31:0] ins, input logic [63:0] x, y,
    input logic [2:0] k, input logic [63:0] d, ad = 0);
    integer t;
    q.push_back('{k, ins[10:6], d, ad});
    @(posedge core_clk);
    go <= 1;
    in_instr <= ins;
    in_a <= x;
    in_b <= y;
    @(posedge core_clk);
    go <= 0;
    for (t = 0; q.size() != 0 && t < 90; t++) @(posedge core_clk);
    if (t >= 90) n_fail++;
    repeat (2) @(posedge core_clk);
  endtask
  function automatic logic [31:0] fi(input logic [5:0] fn,
    input logic [4:0] fm = 5'h11);
    fi = {6'h11, fm, 10'h002, 5'h05, fn};
  endfunction
  // Each answer against the queue head
  always @(negedge core_clk) begin
    if (res_we | mem_we | exc_valid) begin
      if (q.size() == 0) chk(1, 0, "stray answer");
      else begin
        ex = q.pop_front();
        chk(64'({res_we, mem_we, exc_valid}), 64'(ex.k), "kind");
        if (ex.k[2]) chk({res_idx, res_data[58:0]}, {ex.i, ex.d[58:0]}, "res");
        if (ex.k[2]) chk(res_data, ex.d, "data");
        if (ex.k[1]) chk(mem_addr, ex.a, "addr");
        if (ex.k[1]) chk(mem_data, ex.d, "mdata");
        if (ex.k[0]) chk(64'(exc_code), ex.d, "code");
      end
    end
  end
  initial begin
    #500000;
    n_fail++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1;
    rdc(8'h00, 0);
    rdc(8'h10, 0);
    for (i = 0; i < 4; i++) begin
      r = {$random(seed), $random(seed)} & 64'hbfffffffffffffff;
      op(fi(6'h07), r, ~r, 4, {~r[63], r[62:0]});
    end
    op(fi(6'h07, 5'h10), 64'h3f800000, 0, 4, 64'hbf800000);
    op(fi(6'h07) | 32'h10000, 0, 0, 1, `FNR_X_RSVD);
    op(fi(6'h07), 64'h7ff8000000000001, 0, 4, `FNR_QNAN_D);
    rdc(8'h00, 4);
    wb(1, 8'h00, 2);
    op(fi(6'h08), $realtobits(2.5), 0, 4, 2);
    op(fi(6'h0c), $realtobits(3.5), 0, 4, 4);
    op(fi(6'h0c), $realtobits(-2.5), 0, 4, 64'hfffffffe);
    op(fi(6'h0c), 64'h4210000000000000, 0, 4, `FNR_MAX_W);
    op(fi(6'h08), 64'hfff0000000000000, 0, 4, `FNR_MAX_L);
    wb(1, 8'h00, 1);
    op(fi(6'h04), 64'h4000000000000000, 0, 4, 64'h3ff6a09e667f3bcc);
    wb(1, 8'h00, 0);
    op(fi(6'h04), 64'h4000000000000000, 0, 4, 64'h3ff6a09e667f3bcd);
    op(fi(6'h04), 64'h8000000000000000, 0, 4, 64'h8000000000000000);
    rdc(8'h00, 0);
    r = $realtobits(3.0);
    op(fi(6'h01) | 32'h30000, r, 64'h3ff0000000000000, 4,
      64'h4000000000000000);
    op(fi(6'h01) | 32'h30000, 64'h3ff0000000000000, r, 4,
      64'hc000000000000000);
    wb(1, 8'h00, 8);
    wb(1, 8'h08, 1);
    wb(1, 8'h04, 7);
    op(fi(6'h0c), 64'h7ff8000000000000, 0, 1, `FNR_X_INV);
    chk(64'(irq), 1, "irq set");
    rdc(8'h04, 3);
    wb(1, 8'h04, 7);
    @(negedge core_clk);
    chk(64'(irq), 0, "irq clear");
    op(fi(6'h04), 64'hbff0000000000000, 0, 1, `FNR_X_INV);
    wb(1, 8'h00, 0);
    for (i = 0; i < 3; i++) begin
      in_base <= {$random(seed), $random(seed)} & ~64'h7;
      off = $random(seed) & 16'hfff8;
      @(posedge core_clk);
      ea = in_base + {{48{off[15]}}, off};
      r = {$random(seed), $random(seed)};
      op({16'hf486, off}, r, ~r, 2, r, ea);
    end
    wb(1, 8'h0c, 1);
    op({16'hf486, off}, r, ~r, 2, {~r[31:0], r[31:0]}, ea);
    wb(1, 8'h0c, 0);
    in_base <= 64'h1003;
    op(32'hf4860004, r, r, 1, `FNR_X_ADDR);
    in_base <= 64'h1000;
    for (i = 0; i < 4; i++) begin
      in_flg <= ft4[i];
      op(32'hf4860008, r, r, 1, 64'(xc4[i]));
    end
    test_done;
  end
endmodule
`default_nettype wire
